// ==== hw/qec_top.sv ====
// Purpose: Two-channel quadrature encoder counter with APB registers
// Assumes: Encoder pins synchronous to ref_clk, APB zero wait state
// Notes:   Index and rollover events raise a maskable interrupt
//
// The register offsets and the APB interface to the registers were decided locally.
`include "qec_regs.svh"
`default_nettype none
module qec_top (
	// Clock and reset
	input  wire logic                       ref_clk,
	input  wire logic                       rst_n,
	// APB slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [`QEC_AW-1:0]         paddr,
	input  wire logic [31:0]                pwdata,
	input  wire logic [3:0]                 pstrb,
	output var  logic [31:0]                prdata,
	output var  logic                       pready,
	output var  logic                       pslverr,
	// Encoder pins
	input  wire qec_pkg::qec_pins_s [`QEC_NCH-1:0] enc,
	// Status
	output var  logic [2*`QEC_NCH-1:0]      pos_valid,
	output var  logic                       irq
);
	qec_pkg::qec_top_s                 st;
	qec_pkg::qec_top_s                 next_st;
	qec_pkg::qec_step_s [`QEC_NCH-1:0] step;
	qec_pkg::qec_chan_s [`QEC_NCH-1:0] chan;
	logic [2*`QEC_NCH-1:0]             ev;
	logic [2*`QEC_NCH-1:0]             clr;
	logic                              setup;
	logic                              wr;
	logic                              hit;
	logic [31:0]                       rd;
	logic [31:0]                       wv;

	// Per-channel register address
	function automatic logic [`QEC_AW-1:0] ch_addr(
		input logic [`QEC_AW-1:0] base,
		input int unsigned        ch
	);
		ch_addr = base + `QEC_AW'(ch) * `QEC_CH_STEP;
	endfunction

	// Byte-lane merge of a write
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0]  strb
	);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				m[8*i +: 8] = nw[8*i +: 8];
		end
		merge = m;
	endfunction

	// Channels
	for (genvar g = 0; g < `QEC_NCH; g++)
	begin : g_ch
		qec_decode u_dec (
			.ref_clk (ref_clk),
			.rst_n   (rst_n),
			.cfg     (st.cfg[g]),
			.pins    (enc[g]),
			.step    (step[g])
		);

		qec_chan u_chan (
			.ref_clk (ref_clk),
			.rst_n   (rst_n),
			.cfg     (st.cfg[g]),
			.res     (st.res[g]),
			.step    (step[g]),
			.idx     (enc[g].idx),
			.chan    (chan[g])
		);

		assign ev[2*g + `QEC_IRQ_IDX] = chan[g].idx_ev;
		assign ev[2*g + `QEC_IRQ_ROLL] = chan[g].roll_ev;
		assign pos_valid[2*g +: 2] = chan[g].valid;
	end

	// Read decode
	always_comb
	begin
		rd = 32'h0000_0000;
		hit = 1'b0;
		for (int c = 0; c < `QEC_NCH; c++)
		begin
			if (paddr == ch_addr(`QEC_CFG0, c))
			begin
				rd[3:0] = st.cfg[c];
				hit = 1'b1;
			end
			if (paddr == ch_addr(`QEC_RES0, c))
			begin
				rd[`QEC_CNT_W-1:0] = st.res[c];
				hit = 1'b1;
			end
			if (paddr == ch_addr(`QEC_CNT0, c))
			begin
				rd[`QEC_CNT_W-1:0] = chan[c].count;
				hit = 1'b1;
			end
			if (paddr == ch_addr(`QEC_TRN0, c))
			begin
				rd[`QEC_CNT_W-1:0] = chan[c].turns;
				hit = 1'b1;
			end
			if (paddr == ch_addr(`QEC_ANG0, c))
			begin
				rd[`QEC_ANG_W-1:0] = chan[c].angle;
				hit = 1'b1;
			end
		end
		if (paddr == `QEC_VLD)
		begin
			for (int c = 0; c < `QEC_NCH; c++)
				rd[2*c +: 2] = chan[c].valid;
			hit = 1'b1;
		end
		if (paddr == `QEC_IST)
		begin
			rd[2*`QEC_NCH-1:0] = st.ist;
			hit = 1'b1;
		end
		if (paddr == `QEC_IMSK)
		begin
			rd[2*`QEC_NCH-1:0] = st.imsk;
			hit = 1'b1;
		end
	end

	// Register update and APB answer
	always_comb
	begin
		next_st = st;
		wv = 32'h0000_0000;
		clr = '0;
		setup = psel & ~penable;
		wr = psel & penable & st.pready & pwrite & hit;
		next_st.pready = setup;
		next_st.pslverr = setup & ~hit;
		next_st.prdata = (setup && !pwrite && hit) ? rd : 32'h0000_0000;
		for (int c = 0; c < `QEC_NCH; c++)
		begin
			if (wr && paddr == ch_addr(`QEC_CFG0, c))
			begin
				wv = merge({28'h000_0000, st.cfg[c]}, pwdata, pstrb);
				next_st.cfg[c].mode = qec_pkg::qec_mode_e'(
					wv[`QEC_CFG_MODE_LSB +: 2]);
				next_st.cfg[c].ccw = wv[`QEC_CFG_CCW_BIT];
				next_st.cfg[c].cont = wv[`QEC_CFG_CONT_BIT];
			end
			if (wr && paddr == ch_addr(`QEC_RES0, c))
			begin
				wv = merge({8'h00, st.res[c]}, pwdata, pstrb);
				next_st.res[c] = wv[`QEC_CNT_W-1:0];
			end
		end
		if (wr && paddr == `QEC_IMSK)
		begin
			wv = merge({28'h000_0000, st.imsk}, pwdata, pstrb);
			next_st.imsk = wv[2*`QEC_NCH-1:0];
		end
		if (wr && paddr == `QEC_IST && pstrb[0])
			clr = pwdata[2*`QEC_NCH-1:0];
		// Set wins over write-one-to-clear
		next_st.ist = (st.ist & ~clr) | ev;
		next_st.irq = |(next_st.ist & next_st.imsk);
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st <= '0;
			for (int c = 0; c < `QEC_NCH; c++)
			begin
				st.cfg[c] <= qec_pkg::qec_cfg_s'(`QEC_CFG_RST);
				st.res[c] <= `QEC_RES_RST;
			end
			st.imsk <= `QEC_IMSK_RST;
		end
		else
			st <= next_st;
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign irq = st.irq;
endmodule
`default_nettype wire

// ==== hw/qec_regs.svh ====
// Purpose: Register map, field positions and reset values of the counter
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   Included by the package and the top module
// Functional notes
// - Two independent 24-bit up/down counting channels
// - Valid reads 0, becomes 1 at first index
// - First-only: first index clears, later ones ignored
// - First-only: valid goes to -1 on rollover
// - Up from maximum wraps to zero, rollover
// - Down from zero reloads maximum, rollover
// - Continuous: every index clears, valid stays 1
// - Positive direction selectable, reverses counting sense
// - Mode selects single, double or quadruple detection
// - Resolution scales count into turns and angle
// - Turns counts full revolutions, angle the remainder
`ifndef QEC_REGS_SVH
`define QEC_REGS_SVH

`define QEC_CNT_W         24
`define QEC_ANG_W         26
`define QEC_NCH           2
`define QEC_AW            8

`define QEC_CFG0          8'h00
`define QEC_RES0          8'h08
`define QEC_CNT0          8'h10
`define QEC_TRN0          8'h18
`define QEC_ANG0          8'h20
`define QEC_VLD           8'h28
`define QEC_IST           8'h2C
`define QEC_IMSK          8'h30
`define QEC_CH_STEP       8'h04

`define QEC_CFG_MODE_LSB  0
`define QEC_CFG_CCW_BIT   2
`define QEC_CFG_CONT_BIT  3

`define QEC_IRQ_IDX       0
`define QEC_IRQ_ROLL      1

`define QEC_CFG_RST       4'h0
`define QEC_RES_RST       24'h00_0400
`define QEC_IMSK_RST      4'h0

`endif

// ==== hw/qec_pkg.sv ====
// Purpose: Types shared by the quadrature counter modules
// Assumes: Widths from qec_regs.svh
// Notes:   Structs carry pins, steps and channel state
`include "qec_regs.svh"
`default_nettype none
package qec_pkg;

	typedef enum logic [1:0] {
		QEC_SINGLE = 2'b00,
		QEC_DOUBLE = 2'b01,
		QEC_QUAD   = 2'b10
	} qec_mode_e;

	typedef enum logic [1:0] {
		QEC_VLD_NONE = 2'b00,
		QEC_VLD_OK   = 2'b01,
		QEC_VLD_ROLL = 2'b11
	} qec_valid_e;

	typedef struct packed {
		logic      cont;
		logic      ccw;
		qec_mode_e mode;
	} qec_cfg_s;

	typedef struct packed {
		logic a;
		logic b;
		logic idx;
	} qec_pins_s;

	typedef struct packed {
		logic step;
		logic up;
	} qec_step_s;

	typedef struct packed {
		logic      a;
		logic      b;
		qec_step_s step;
	} qec_dec_s;

	typedef struct packed {
		logic [`QEC_CNT_W-1:0] count;
		logic [`QEC_ANG_W-1:0] angle;
		logic [`QEC_CNT_W-1:0] turns;
		qec_valid_e            valid;
		logic                  started;
		logic                  idx_q;
		logic                  idx_ev;
		logic                  roll_ev;
	} qec_chan_s;

	typedef struct packed {
		qec_cfg_s [`QEC_NCH-1:0]              cfg;
		logic [`QEC_NCH-1:0][`QEC_CNT_W-1:0]  res;
		logic [2*`QEC_NCH-1:0]                ist;
		logic [2*`QEC_NCH-1:0]                imsk;
		logic [31:0]                          prdata;
		logic                                 pready;
		logic                                 pslverr;
		logic                                 irq;
	} qec_top_s;

	// Counts per revolution, resolution times mode factor
	function automatic logic [`QEC_ANG_W-1:0] qec_cpr(
		input logic [`QEC_CNT_W-1:0] res,
		input qec_mode_e             mode
	);
		logic [`QEC_ANG_W-1:0] r;
		r = (res == '0) ? `QEC_ANG_W'(1) : `QEC_ANG_W'(res);
		unique case (mode)
			QEC_DOUBLE: qec_cpr = r << 1;
			QEC_QUAD:   qec_cpr = r << 2;
			default:    qec_cpr = r;
		endcase
	endfunction

endpackage
`default_nettype wire

// ==== hw/qec_decode.sv ====
// Purpose: Phase decoder, turns encoder edges into count steps
// Assumes: Phase inputs synchronous to ref_clk
// Notes:   Simultaneous edges on both phases are dropped
`default_nettype none
module qec_decode (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	// Configuration and phases
	input  wire qec_pkg::qec_cfg_s cfg,
	input  wire qec_pkg::qec_pins_s pins,
	// Count step
	output var  qec_pkg::qec_step_s step
);
	qec_pkg::qec_dec_s st;
	qec_pkg::qec_dec_s next_st;
	logic              ea;
	logic              eb;
	logic              hit;
	logic              cw;

	always_comb
	begin
		next_st = st;
		next_st.a = pins.a;
		next_st.b = pins.b;
		ea = pins.a ^ st.a;
		eb = pins.b ^ st.b;
		hit = 1'b0;
		cw = 1'b0;
		unique case (cfg.mode)
			qec_pkg::QEC_SINGLE:
			begin
				hit = ea & pins.a & ~eb;
				cw = ~pins.b;
			end
			qec_pkg::QEC_DOUBLE:
			begin
				hit = ea & ~eb;
				cw = pins.a ^ pins.b;
			end
			qec_pkg::QEC_QUAD:
			begin
				hit = ea ^ eb;
				cw = ea ? (pins.a ^ pins.b) : ~(pins.a ^ pins.b);
			end
			default:
			begin
				hit = 1'b0;
				cw = 1'b0;
			end
		endcase
		next_st.step.step = hit;
		next_st.step.up = cw ^ cfg.ccw;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign step = st.step;
endmodule
`default_nettype wire

// ==== hw/qec_chan.sv ====
// Purpose: One position channel: counter, turns, angle, valid state
// Assumes: One step at most per clock from the decoder
// Notes:   Counting starts only at the first index
`include "qec_regs.svh"
`default_nettype none
module qec_chan (
	// Clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	// Configuration
	input  wire qec_pkg::qec_cfg_s       cfg,
	input  wire logic [`QEC_CNT_W-1:0]   res,
	// Steps and index
	input  wire qec_pkg::qec_step_s      step,
	input  wire logic                    idx,
	// Channel state
	output var  qec_pkg::qec_chan_s      chan
);
	qec_pkg::qec_chan_s    st;
	qec_pkg::qec_chan_s    next_st;
	logic [`QEC_ANG_W-1:0] cpr;
	logic                  roll;

	always_comb
	begin
		next_st = st;
		next_st.idx_q = idx;
		next_st.idx_ev = 1'b0;
		next_st.roll_ev = 1'b0;
		roll = 1'b0;
		cpr = qec_pkg::qec_cpr(res, cfg.mode);
		if (idx && !st.idx_q && (!st.started || cfg.cont))
		begin
			next_st.count = '0;
			next_st.angle = '0;
			next_st.turns = '0;
			next_st.started = 1'b1;
			next_st.valid = qec_pkg::QEC_VLD_OK;
			next_st.idx_ev = 1'b1;
		end
		else if (st.started && step.step)
		begin
			if (step.up)
			begin
				roll = (st.count == '1);
				next_st.count = st.count + 1'b1;
				if (st.angle + 1'b1 >= cpr)
				begin
					next_st.angle = '0;
					next_st.turns = st.turns + 1'b1;
				end
				else
					next_st.angle = st.angle + 1'b1;
			end
			else
			begin
				roll = (st.count == '0);
				next_st.count = st.count - 1'b1;
				if (st.angle == '0 || st.angle >= cpr)
				begin
					next_st.angle = cpr - 1'b1;
					next_st.turns = st.turns - 1'b1;
				end
				else
					next_st.angle = st.angle - 1'b1;
			end
			next_st.roll_ev = roll;
			if (roll && !cfg.cont)
				next_st.valid = qec_pkg::QEC_VLD_ROLL;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign chan = st;
endmodule
`default_nettype wire

// ==== test/qec_assertions.sv ====
// Purpose: Port checks of the encoder counter
// Assumes: Bound to qec_top, one clock
// Notes:   Sees only the top ports
`include "qec_regs.svh"
`default_nettype none
module qec_assertions (
	// Clock and reset
	input wire logic                              ref_clk,
	input wire logic                              rst_n,
	// APB
	input wire logic                              psel,
	input wire logic                              penable,
	input wire logic                              pready,
	input wire logic                              pslverr,
	// Encoder and status
	input wire qec_pkg::qec_pins_s [`QEC_NCH-1:0] enc,
	input wire logic [2*`QEC_NCH-1:0]             pos_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	ready_zero_wait_a: assert property (psel && !penable |=> pready)
		else $error("pready not one cycle after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held past one cycle");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	valid_code_a: assert property (pos_valid[1:0] != 2'b10)
		else $error("illegal valid code");
	valid_set_a: assert property ($rose(enc[0].idx) |=>
		pos_valid[1:0] != 2'b00)
		else $error("valid not set by index");
	valid_cause_a: assert property ($rose(pos_valid[2]) |->
		$past(enc[1].idx))
		else $error("valid set without index");
	roll_keep_a: assert property (pos_valid[1:0] == 2'b11 |=>
		pos_valid[1:0] == 2'b11)
		else $error("rollover flag lost");
	valid_keep_a: assert property (pos_valid[3:2] != 2'b00 |=>
		pos_valid[3:2] == 2'b01)
		else $error("continuous valid left 01");
endmodule
`default_nettype wire

// ==== test/qec_enc_model.sv ====
// Purpose: Two incremental encoders with index
// Assumes: Pins move just after rising edges
// Notes:   Phase a leads b when turning clockwise
`include "qec_regs.svh"
`default_nettype none
module qec_enc_model (
	// Clock
	input wire logic                             ref_clk,
	// Encoder pins
	output var qec_pkg::qec_pins_s [`QEC_NCH-1:0] enc
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ph [`QEC_NCH];

	initial
	begin
		enc = '0;
		ph[0] = 2'h0;
		ph[1] = 2'h0;
	end

	// Quarter steps, gap+1 edges apart
	task turn(input int ch, input bit cw, input int n, input int gap);
		for (int i = 0; i < n; i++)
		begin
			@(posedge ref_clk);
			ph[ch] = cw ? ph[ch] + 2'h1 : ph[ch] - 2'h1;
			enc[ch].a <= ^ph[ch];
			enc[ch].b <= ph[ch][1];
			repeat (gap) @(posedge ref_clk);
		end
	endtask

	task pulse(input int ch);
		@(posedge ref_clk);
		enc[ch].idx <= 1'b1;
		repeat (2) @(posedge ref_clk);
		enc[ch].idx <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

// ==== test/tb_quadrature_encoder_counter.sv ====
// Purpose: Register level test of the encoder counter
// Assumes: APB master on rising edges
// Notes:   One verdict line at the end
`include "qec_regs.svh"
`default_nettype none
module tb_quadrature_encoder_counter;
	timeunit 1ns;
	timeprecision 1ps;
	logic                              ref_clk, rst_n, irq, e;
	logic                              psel, penable, pwrite;
	logic                              pready, pslverr;
	logic [7:0]                        paddr;
	logic [31:0]                       pwdata, prdata, d;
	logic [3:0]                        pos_valid, pstrb;
	qec_pkg::qec_pins_s [`QEC_NCH-1:0] enc;
	int                                errors, n_compared;

	qec_top qec_top_inst (.ref_clk, .rst_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.enc, .pos_valid, .irq);
	qec_enc_model qec_enc_model_inst (.ref_clk, .enc);

	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic chk(input string s, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %s exp %h seen %h", s, exp, seen);
		end
	endtask

	task automatic results;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
		if (k >= 20)
		begin
			errors++;
			results;
		end
	endtask

	task automatic rchk(input string s, input logic [7:0] a,
		input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000);
		chk(s, d, x);
	endtask

	task automatic pins(input logic i, input logic [3:0] v);
		repeat (2) @(negedge ref_clk);
		chk("irq", 32'(irq), 32'(i));
		chk("pos_valid", 32'(pos_valid), 32'(v));
		@(posedge ref_clk);
	endtask

	initial
	begin
		rst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hF;
		errors = 0;
		n_compared = 0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		rchk("cfg0", `QEC_CFG0, 32'h0000_0000);
		rchk("res0", `QEC_RES0, 32'h0000_0400);
		rchk("imsk", `QEC_IMSK, 32'h0000_0000);
		rchk("vld", `QEC_VLD, 32'h0000_0000);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk("slverr", 32'(e), 32'h0000_0001);
		apb(1'b1, `QEC_RES0, 32'h0000_0004);
		apb(1'b1, `QEC_CFG0, 32'h0000_0002);
		qec_enc_model_inst.turn(0, 1, 3, 2);
		rchk("cnt0 idle", `QEC_CNT0, 32'h0000_0000);
		qec_enc_model_inst.pulse(0);
		pins(1'b0, 4'h1);
		rchk("ist", `QEC_IST, 32'h0000_0001);
		apb(1'b1, `QEC_IMSK, 32'h0000_000F);
		pins(1'b1, 4'h1);
		apb(1'b1, `QEC_IST, 32'h0000_0001);
		pins(1'b0, 4'h1);
		qec_enc_model_inst.turn(0, 1, 18, 2);
		rchk("cnt0", `QEC_CNT0, 32'h0000_0012);
		rchk("trn0", `QEC_TRN0, 32'h0000_0001);
		rchk("ang0", `QEC_ANG0, 32'h0000_0002);
		qec_enc_model_inst.turn(0, 0, 20, 5);
		rchk("cnt0 down", `QEC_CNT0, 32'h00FF_FFFE);
		rchk("trn0 neg", `QEC_TRN0, 32'h00FF_FFFF);
		rchk("ang0 neg", `QEC_ANG0, 32'h0000_000E);
		pins(1'b1, 4'h3);
		pstrb <= 4'h2;
		apb(1'b1, `QEC_IST, 32'h0000_0002);
		pstrb <= 4'hF;
		rchk("ist kept", `QEC_IST, 32'h0000_0002);
		qec_enc_model_inst.pulse(0);
		rchk("cnt0 late idx", `QEC_CNT0, 32'h00FF_FFFE);
		qec_enc_model_inst.turn(0, 1, 3, 2);
		rchk("cnt0 wrap", `QEC_CNT0, 32'h0000_0001);
		apb(1'b1, `QEC_IST, 32'h0000_000F);
		pins(1'b0, 4'h3);
		for (int m = 0; m < 3; m++)
		begin
			apb(1'b1, `QEC_CFG0 + `QEC_CH_STEP, 32'(8 + m));
			qec_enc_model_inst.pulse(1);
			rchk("cnt1 idx", `QEC_CNT0 + `QEC_CH_STEP, 32'h0000_0000);
			qec_enc_model_inst.turn(1, 1, 8, 2);
			rchk("cnt1 mode", `QEC_CNT0 + `QEC_CH_STEP, 32'(2 << m));
		end
		apb(1'b1, `QEC_CFG0 + `QEC_CH_STEP, 32'h0000_000B);
		qec_enc_model_inst.turn(1, 1, 4, 2);
		rchk("cnt1 off", `QEC_CNT0 + `QEC_CH_STEP, 32'h0000_0008);
		apb(1'b1, `QEC_CFG0 + `QEC_CH_STEP, 32'h0000_000E);
		qec_enc_model_inst.pulse(1);
		qec_enc_model_inst.turn(1, 1, 8, 2);
		rchk("cnt1 ccw", `QEC_CNT0 + `QEC_CH_STEP, 32'h00FF_FFF8);
		qec_enc_model_inst.turn(1, 0, 4, 2);
		rchk("cnt1 back", `QEC_CNT0 + `QEC_CH_STEP, 32'h00FF_FFFC);
		rchk("vld both", `QEC_VLD, 32'h0000_0007);
		rchk("cnt0 kept", `QEC_CNT0, 32'h0000_0001);
		results;
	end
endmodule

bind qec_top qec_assertions qec_assertions_inst (.ref_clk, .rst_n, .psel,
	.penable, .pready, .pslverr, .enc, .pos_valid);
`default_nettype wire
